// *** pfdc_top.sv ***
// Packet filter, checksum and DC-free line coder with a 66-byte FIFO.
`timescale 1ns/10ps
// Notes on behaviour
// - Level flags serve FIFO during long packets.
// - Sent flag after last bit leaves.
// - Packets without sync are silently dropped.
// - Sync starts payload; sets match only with filter off.
// - Filter 01 keeps node address matches.
// - Filter 10 keeps node or broadcast.
// - Address byte stays payload; receive only.
// - Address checked after sync; shared flag.
// - Variable length kept only below maximum.
// - Length byte kept; 255 disables check.
// - Transmit appends two checksum bytes.
// - Receive checks checksum, sets pass bit.
// - Bad checksum clears FIFO unless kept.
// - Checksum bytes never enter FIFO.
// - CCITT checksum catches leading, trailing zeros.
// - Manchester: one is 10, zero 01.
// - Only payload and checksum are coded.
// - Whitening XORs payload and checksum.
module pfdc_top
   import pfdc_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,   // FIFO bytes.
   parameter int SYNC_BYTES = 4        // Used sync pattern bytes.
)(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Configuration.
   input  wire logic        rx_mode,
   input  wire logic        tx_go,
   input  wire logic        var_len,
   input  wire logic [1:0]  addr_filter_sel,
   input  wire logic [7:0]  own_node_id,
   input  wire logic [7:0]  group_node_id,
   input  wire logic [7:0]  max_len_setting,
   input  wire logic        checksum_enable,
   input  wire logic        keep_bad_packet,
   input  wire logic [1:0]  line_balance_sel,
   input  wire logic [63:0] sync_pattern_bytes,
   input  wire logic [6:0]  fifo_mark,
   // Host FIFO port.
   input  wire logic        host_wr,
   input  wire logic [7:0]  host_wdata,
   input  wire logic        host_rd,
   output logic [7:0]       host_rdata,
   // Status flags.
   output logic             fifo_level_over_mark,
   output logic             fifo_full_flag,
   output logic             fifo_nonempty_flag,
   output logic             tx_packet_done,
   output logic             rx_payload_done,
   output logic             checksum_pass,
   output logic             sync_or_addr_hit,
   // Modem chip stream.
   input  wire logic        rx_chip,
   input  wire logic        rx_chip_en,
   output logic             tx_chip,
   output logic             tx_chip_en
);
   localparam int SW = SYNC_BYTES * 8;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0]  mem [DEPTH];             // FIFO storage.
   logic [6:0]  wp_q, wp_d, rp_q, rp_d;  // FIFO pointers.
   logic [6:0]  cnt_q, cnt_d;            // FIFO level.
   pfdc_state_t st_q, st_d;              // Sequencer state.
   logic [SW-1:0] shf_q, shf_d;          // Sync shift register.
   logic [7:0]  byt_q, byt_d;            // Byte assembly.
   logic [2:0]  bit_q, bit_d;            // Bit index.
   logic [7:0]  len_q, len_d;            // Bytes left in payload.
   logic [7:0]  idx_q, idx_d;            // Payload byte index.
   logic        half_q, half_d;          // Manchester half chip.
   logic        fch_q, fch_d;            // First Manchester chip.
   logic        eng_wr, eng_rd;          // Engine FIFO strobes.
   logic [7:0]  eng_wdata;               // Engine FIFO data.
   logic        flush;                   // FIFO clear request.
   logic        crc_init, crc_en, crc_bit;
   logic [15:0] crc_q;
   logic        w_init, w_step, wbit;
   logic        dbit;                    // Decoded or source bit.
   logic        dvalid;                  // Decoded bit strobe.
   logic        ncoded;                  // Current section is coded.
   logic        rx_s1_q, rx_s2_q, rx_s3_q, rxe_s1_q, rxe_s2_q, rxe_s3_q;
   logic        rx_b, rx_e;              // Agreed synchronised inputs.
   logic        rx_b_q, rx_e_q;          // Held agreed levels.
   logic        ch_q, ch_d, chen_d;      // Transmit chip.
   logic        sent_d, rdy_d, ok_d, hit_d;
   logic        add_ok;                  // Address accepted.

   // ----------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------
   // Three stages; a change counts once stages two and three agree.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         {rx_s1_q, rx_s2_q, rx_s3_q, rxe_s1_q, rxe_s2_q, rxe_s3_q} <= 6'h00;
         rx_b_q <= 1'b0;
         rx_e_q <= 1'b0;
      end else begin
         {rx_s1_q, rx_s2_q, rx_s3_q} <= {rx_chip, rx_s1_q, rx_s2_q};
         {rxe_s1_q, rxe_s2_q, rxe_s3_q} <= {rx_chip_en, rxe_s1_q, rxe_s2_q};
         rx_b_q <= rx_b;
         rx_e_q <= (rxe_s2_q == rxe_s3_q) ? rxe_s2_q : rx_e_q;
      end
   end
   assign rx_b = (rx_s2_q == rx_s3_q) ? rx_s2_q : rx_b_q;
   // The chip strobe is the rising edge of the agreed enable level.
   assign rx_e = (rxe_s2_q == rxe_s3_q) && rxe_s2_q && !rx_e_q;

   // ----------------------------------------------------------------
   // Sub-blocks
   // ----------------------------------------------------------------
   // CCITT checksum engine
   pfdc_crc u_crc (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .init    (crc_init),
      .bit_en  (crc_en),
      .bit_in  (crc_bit),
      .crc_q   (crc_q)
   );
   pfdc_white u_white (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .init    (w_init),
      .step    (w_step),
      .wbit    (wbit)
   );

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q; shf_d = shf_q; byt_d = byt_q; bit_d = bit_q;
      len_d = len_q; idx_d = idx_q; half_d = half_q; fch_d = fch_q;
      ch_d = ch_q; chen_d = 1'b0; eng_wr = 1'b0; eng_rd = 1'b0;
      eng_wdata = byt_q; flush = 1'b0; crc_init = 1'b0; crc_en = 1'b0;
      crc_bit = 1'b0; w_init = 1'b0; w_step = 1'b0; dbit = 1'b0;
      dvalid = 1'b0; sent_d = 1'b0; rdy_d = 1'b0; ok_d = checksum_pass;
      hit_d = 1'b0; add_ok = 1'b1;
      ncoded = (st_q == PF_PAY) || (st_q == PF_CRC);
      unique case (st_q)
         PF_IDLE: begin
            shf_d = '0; half_d = 1'b0; bit_d = 3'h0; idx_d = 8'h00;
            crc_init = 1'b1; w_init = 1'b1;
            if (rx_mode) st_d = PF_SYNC;
            else if (tx_go && cnt_q != 7'h00) begin
               st_d = PF_SYNC; shf_d = sync_pattern_bytes[63 -: SW];
               len_d = 8'(SW);
            end
         end
         PF_SYNC: begin
            if (rx_mode && rx_e) begin
               // No match keeps hunting; nothing is flagged.
               shf_d = {shf_q[SW-2:0], rx_b};
               if (shf_d == sync_pattern_bytes[63 -: SW]) begin
                  st_d = PF_PAY; fch_d = 1'b1;
                  hit_d = (addr_filter_sel == AF_OFF);
                  len_d = max_len_setting;
               end
            end else if (!rx_mode) begin
               // Sync is sent plain NRZ, one chip per clock.
               chen_d = 1'b1; ch_d = shf_q[SW-1];
               shf_d = {shf_q[SW-2:0], 1'b0}; len_d = len_q - 8'h01;
               if (len_q == 8'h01) begin
                  st_d = PF_PAY; len_d = max_len_setting; half_d = 1'b0;
               end
            end
         end
         PF_PAY, PF_CRC: begin
            if (rx_mode) begin
               // Manchester pairs chips; 10 decodes to one.
               if (rx_e) begin
                  if (line_balance_sel == LB_MANCH) begin
                     half_d = !half_q;
                     fch_d = rx_b;
                     dvalid = half_q; dbit = fch_q;
                  end else begin
                     dvalid = 1'b1; dbit = rx_b;
                  end
               end
               // Undo whitening before the byte is used.
               if (dvalid && line_balance_sel == LB_WHITE) begin
                  dbit = dbit ^ wbit; w_step = 1'b1;
               end
               if (dvalid) begin
                  byt_d = {byt_q[6:0], dbit}; bit_d = bit_q + 3'h1;
                  crc_en = checksum_enable && st_q == PF_PAY;
                  crc_bit = dbit;
                  if (bit_q == 3'h7) begin
                     if (st_q == PF_PAY) begin
                        eng_wr = 1'b1; eng_wdata = byt_d;
                        idx_d = idx_q + 8'h01; len_d = len_q - 8'h01;
                        if (idx_q == 8'h00 && var_len) begin
                           len_d = byt_d;
                           if (max_len_setting != LEN_NO_LIMIT &&
                               byt_d >= max_len_setting) begin
                              flush = 1'b1; st_d = PF_IDLE;
                           end
                        end else if (idx_q == (var_len ? 8'h01 : 8'h00) &&
                                     addr_filter_sel != AF_OFF) begin
                           // Node, or group when enabled.
                           // The byte is judged once complete, not while shifting.
                           add_ok = (byt_d == own_node_id) ||
                                    (byt_d == group_node_id &&
                                     addr_filter_sel == AF_NODE_GROUP);
                           if (add_ok) hit_d = 1'b1;
                           else begin
                              flush = 1'b1; st_d = PF_IDLE;
                           end
                        end
                        if (len_d == 8'h00 && st_d != PF_IDLE) begin
                           st_d = checksum_enable ? PF_CRC : PF_DONE;
                           len_d = 8'h02;
                        end
                     end else begin
                        len_d = len_q - 8'h01;
                        if (len_q == 8'h01) st_d = PF_DONE;
                     end
                  end
                  if (st_q == PF_CRC) begin
                     shf_d = {shf_q[SW-2:0], dbit};
                  end
               end
            end else begin
               // Transmit: payload bytes then two checksum bytes.
               chen_d = 1'b1;
               if (bit_q == 3'h0 && !half_q) begin
                  if (st_q == PF_PAY && cnt_q == 7'h00) chen_d = 1'b0;
                  else if (st_q == PF_PAY) begin
                     eng_rd = 1'b1; byt_d = mem[rp_q];
                  end else byt_d = len_q[1] ? ~crc_q[15:8] : ~crc_q[7:0];
               end
               dbit = byt_d[7];
               if (chen_d) begin
                  if (line_balance_sel == LB_WHITE) dbit = dbit ^ wbit;
                  // A one goes out as 10, a zero as 01.
                  if (line_balance_sel == LB_MANCH) begin
                     ch_d = half_q ? !dbit : dbit; half_d = !half_q;
                  end else ch_d = dbit;
                  if (line_balance_sel != LB_MANCH || half_q) begin
                     w_step = (line_balance_sel == LB_WHITE);
                     crc_en = checksum_enable && st_q == PF_PAY;
                     crc_bit = byt_d[7];
                     byt_d = {byt_d[6:0], 1'b0}; bit_d = bit_q + 3'h1;
                     if (bit_q == 3'h7) begin
                        len_d = len_q - 8'h01;
                        if (st_q == PF_PAY && var_len && idx_q == 8'h00)
                           len_d = byt_q;
                        idx_d = idx_q + 8'h01;
                        if (len_d == 8'h00) begin
                           st_d = (st_q == PF_PAY && checksum_enable) ?
                                  PF_CRC : PF_DONE;
                           len_d = 8'h02;
                        end
                     end
                  end
               end
            end
         end
         PF_DONE: begin
            st_d = PF_IDLE;
            if (rx_mode) begin
               // Compare with the inverted final value.
               ok_d = !checksum_enable || (shf_q[15:0] == ~crc_q);
               // Bad sum clears FIFO silently unless kept.
               if (ok_d || keep_bad_packet) rdy_d = 1'b1;
               else flush = 1'b1;
            end else begin
               // Flag only after the final chip has gone out.
               sent_d = 1'b1;
            end
         end
         default: st_d = PF_IDLE;
      endcase
      if (st_q == PF_IDLE && !rx_mode && !tx_go) ch_d = 1'b0;
      if (ncoded && line_balance_sel == LB_NONE) w_step = 1'b0;
   end

   // ----------------------------------------------------------------
   // FIFO next state
   // ----------------------------------------------------------------
   // Level flags let the host service a long packet in flight.
   always_comb begin
      logic wr, rd;
      wr = (eng_wr || (host_wr && !rx_mode)) && cnt_q != 7'(DEPTH);
      rd = (eng_rd || (host_rd && rx_mode)) && cnt_q != 7'h00;
      wp_d = wr ? ((wp_q == 7'(DEPTH - 1)) ? 7'h00 : wp_q + 7'h01) : wp_q;
      rp_d = rd ? ((rp_q == 7'(DEPTH - 1)) ? 7'h00 : rp_q + 7'h01) : rp_q;
      cnt_d = cnt_q + (wr ? 7'h01 : 7'h00) - (rd ? 7'h01 : 7'h00);
      if (flush) begin
         wp_d = 7'h00; rp_d = 7'h00; cnt_d = 7'h00;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         st_q <= PF_IDLE; shf_q <= '0; byt_q <= 8'h00; bit_q <= 3'h0;
         len_q <= 8'h00; idx_q <= 8'h00; half_q <= 1'b0; fch_q <= 1'b0;
         ch_q <= 1'b0; wp_q <= 7'h00; rp_q <= 7'h00; cnt_q <= 7'h00;
         tx_chip <= 1'b0; tx_chip_en <= 1'b0; tx_packet_done <= 1'b0;
         rx_payload_done <= 1'b0; checksum_pass <= 1'b0;
         sync_or_addr_hit <= 1'b0; host_rdata <= 8'h00;
         fifo_level_over_mark <= 1'b0; fifo_full_flag <= 1'b0;
         fifo_nonempty_flag <= 1'b0;
      end else begin
         st_q <= st_d; shf_q <= shf_d; byt_q <= byt_d; bit_q <= bit_d;
         len_q <= len_d; idx_q <= idx_d; half_q <= half_d; fch_q <= fch_d;
         ch_q <= ch_d; wp_q <= wp_d; rp_q <= rp_d; cnt_q <= cnt_d;
         tx_chip <= ch_d; tx_chip_en <= chen_d;
         tx_packet_done <= sent_d; rx_payload_done <= rdy_d;
         checksum_pass <= ok_d; sync_or_addr_hit <= hit_d;
         host_rdata <= mem[rp_q];
         fifo_level_over_mark <= cnt_d > fifo_mark;
         fifo_full_flag <= cnt_d == 7'(DEPTH);
         fifo_nonempty_flag <= cnt_d != 7'h00;
      end
   end

   // FIFO storage, written without reset.
   always_ff @(posedge ref_clk) begin
      if (eng_wr && cnt_q != 7'(DEPTH)) mem[wp_q] <= eng_wdata;
      else if (host_wr && !rx_mode && cnt_q != 7'(DEPTH)) mem[wp_q] <= host_wdata;
   end
endmodule : pfdc_top

// *** pfdc_pkg.sv ***
// Shared constants for the packet filter and DC-free coder.
package pfdc_pkg;
   // ----------------------------------------------------------------
   // Sizes and settings
   // ----------------------------------------------------------------
   localparam int          FIFO_DEPTH      = 66;      // FIFO bytes.
   localparam logic [1:0]  AF_OFF          = 2'h0;    // No address filter.
   localparam logic [1:0]  AF_NODE         = 2'h1;    // Node address only.
   localparam logic [1:0]  AF_NODE_GROUP   = 2'h2;    // Node or broadcast.
   localparam logic [1:0]  LB_NONE         = 2'h0;    // Plain NRZ.
   localparam logic [1:0]  LB_MANCH        = 2'h1;    // Manchester chips.
   localparam logic [1:0]  LB_WHITE        = 2'h2;    // LFSR whitening.
   localparam logic [15:0] CRC_POLY        = 16'h1021; // CCITT generator.
   localparam logic [15:0] CRC_SEED        = 16'h1D0F; // Checksum seed.
   localparam logic [8:0]  WHITE_SEED      = 9'h1FF;   // Whitening seed.
   localparam logic [7:0]  LEN_NO_LIMIT    = 8'hFF;    // Disables length check.
   localparam int          SYNC_MAX_BYTES  = 8;        // Sync pattern bytes.

   // Receive and transmit sequencer states.
   typedef enum logic [2:0] {
      PF_IDLE  = 3'b000,
      PF_SYNC  = 3'b001,
      PF_PAY   = 3'b010,
      PF_CRC   = 3'b011,
      PF_DONE  = 3'b100
   } pfdc_state_t;
endpackage : pfdc_pkg

// *** pfdc_crc.sv ***
// CCITT checksum engine, one bit per clock, most significant bit first.
`timescale 1ns/10ps
module pfdc_crc
   import pfdc_pkg::*;
(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Control.
   input  wire logic        init,
   input  wire logic        bit_en,
   input  wire logic        bit_in,
   // Result.
   output logic [15:0]      crc_q
);
   logic [15:0] crc_d;   // Next checksum state.
   logic        fb;      // Feedback bit.

   // ----------------------------------------------------------------
   // Next value
   // ----------------------------------------------------------------
   // Seeding with a non-zero value lets leading zeros change the sum.
   always_comb begin
      fb    = crc_q[15] ^ bit_in;
      crc_d = crc_q;
      if (init) begin
         crc_d = CRC_SEED;
      end else if (bit_en) begin
         crc_d = {crc_q[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
   end

   // Register stage.
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         crc_q <= CRC_SEED;
      end else begin
         crc_q <= crc_d;
      end
   end
endmodule : pfdc_crc

// *** pfdc_white.sv ***
// Nine-bit whitening sequence generator, polynomial x^9 + x^5 + 1.
`timescale 1ns/10ps
module pfdc_white
   import pfdc_pkg::*;
(
   // Clock and reset.
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // Control.
   input  wire logic        init,
   input  wire logic        step,
   // Current whitening bit.
   output logic             wbit
);
   logic [8:0] lfsr_q;   // Shift register.
   logic [8:0] lfsr_d;   // Next value.

   // ----------------------------------------------------------------
   // Next value
   // ----------------------------------------------------------------
   always_comb begin
      lfsr_d = lfsr_q;
      if (init) begin
         lfsr_d = WHITE_SEED;
      end else if (step) begin
         lfsr_d = {lfsr_q[0] ^ lfsr_q[5], lfsr_q[8:1]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         lfsr_q <= WHITE_SEED;
      end else begin
         lfsr_q <= lfsr_d;
      end
   end

   assign wbit = lfsr_q[0];
endmodule : pfdc_white

// *** pfdc_sva.sv ***
// Checker of the packet coder's flags and stream.
`timescale 1ns/10ps
module pfdc_sva
   import pfdc_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic nrst,
   // Watched ports.
   input wire logic rx_mode,
   input wire logic checksum_enable,
   input wire logic keep_bad_packet,
   input wire logic host_wr,
   input wire logic fifo_full_flag,
   input wire logic fifo_nonempty_flag,
   input wire logic tx_packet_done,
   input wire logic rx_payload_done,
   input wire logic checksum_pass,
   input wire logic sync_or_addr_hit,
   input wire logic tx_chip_en
);
   logic seen_d; // Next hit memory.
   logic seen_q; // Hit seen in this packet.
   // Remembers the hit until the done pulse.
   always_comb seen_d = sync_or_addr_hit | (seen_q & ~rx_payload_done);
   always_ff @(posedge ref_clk) seen_q <= nrst & seen_d;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // First write into an empty transmit FIFO.
   sequence s_first_wr;
      host_wr && !rx_mode && !fifo_nonempty_flag && !fifo_full_flag;
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0)
      !nrst |=> !fifo_nonempty_flag && !tx_chip_en && !checksum_pass)
      else $error("busy after reset");
   a_sent_idle: assert property (tx_packet_done |-> !tx_chip_en)
      else $error("sent while sending");
   a_sent_pulse: assert property (tx_packet_done |=> !tx_packet_done)
      else $error("sent too long");
   a_done_pulse: assert property (rx_payload_done |=> !rx_payload_done)
      else $error("done too long");
   a_hit_pulse: assert property (sync_or_addr_hit |=> !sync_or_addr_hit)
      else $error("hit too long");
   a_hit_first: assert property (rx_payload_done |-> seen_q)
      else $error("done without hit");
   a_hit_rx_only: assert property (sync_or_addr_hit |-> rx_mode)
      else $error("hit in transmit");
   a_full_level: assert property (fifo_full_flag |-> fifo_nonempty_flag)
      else $error("full yet empty");
   a_first_write: assert property (s_first_wr |=> ##1 fifo_nonempty_flag)
      else $error("write lost");
   a_pass_on_done: assert property (rx_payload_done && checksum_enable
      && !keep_bad_packet |-> ##[0:1] checksum_pass)
      else $error("done with bad sum");
endmodule : pfdc_sva

bind pfdc_top pfdc_sva u_sva (.*);

// *** pfdc_host.sv ***
// Host model that services the FIFO by its flags.
`timescale 1ns/10ps
module pfdc_host (
   // Clock and flags.
   input  wire logic       ref_clk,
   input  wire logic       fifo_level_over_mark,
   input  wire logic       fifo_full_flag,
   input  wire logic       fifo_nonempty_flag,
   input  wire logic [7:0] host_rdata,
   // FIFO strobes.
   output logic            host_wr = 1'b0,
   output logic [7:0]      host_wdata = 8'h00,
   output logic            host_rd = 1'b0
);
   // A gap of two lets each write reach the flags first.
   // flag paced refill
   task automatic send(input logic [7:0] q[$], input int gap);
      int i;
      i = 0;
      for (int t = 0; t < 20000 && i < q.size(); t++) begin
         @(negedge ref_clk);
         if (host_wr) begin
            host_wr = 1'b0;
            host_wdata = ~host_wdata;
         end
         if (t % gap == 0 && !fifo_level_over_mark && !fifo_full_flag) begin
            host_wr = 1'b1;
            host_wdata = q[i];
            i++;
         end
      end
      @(negedge ref_clk);
      host_wr = 1'b0;
   endtask : send
   task automatic take(output logic [7:0] q[$]);
      q = {};
      for (int t = 0; t < 400; t++) begin
         @(negedge ref_clk);
         host_rd = 1'b0;
         if (t % 2 == 0 && fifo_nonempty_flag === 1'b1) begin
            q.push_back(host_rdata);
            host_rd = 1'b1;
         end
      end
   endtask : take
endmodule : pfdc_host

// *** pfdc_top_tb.sv ***
// Self-checking bench of the packet coder.
`timescale 1ns/10ps
module pfdc_top_tb
   import pfdc_pkg::*;
;
   localparam int SB = 4; // Sync bytes in use.
   localparam logic [63:0] SYNC = 64'hA5C3_5A3C_9669_1EE1;
   logic ref_clk = 1'b0, nrst = 1'b0, rx_mode = 1'b0, tx_go = 1'b0, var_len = 1'b0;
   logic checksum_enable = 1'b1, keep_bad_packet = 1'b0, rx_chip = 1'b0, rx_chip_en = 1'b0;
   logic [1:0] addr_filter_sel = 2'h0, line_balance_sel = 2'h0;
   logic [7:0] own_node_id = 8'h5A, group_node_id = 8'hA5, max_len_setting = 8'h04;
   logic [6:0] fifo_mark = 7'h14;
   logic host_wr, host_rd, fifo_level_over_mark, fifo_full_flag, fifo_nonempty_flag;
   logic tx_packet_done, rx_payload_done, checksum_pass, sync_or_addr_hit, tx_chip, tx_chip_en;
   logic [7:0] host_wdata, host_rdata, pay[$];
   logic [15:0] crc;
   logic [8:0] wh;
   logic [31:0] rs = 32'h0000_7387;
   bit chips[$];
   int errors, n_checks, hit_n, done_n, sent_n;
   pfdc_top #(.SYNC_BYTES(SB)) DUT (.*, .sync_pattern_bytes(SYNC));
   pfdc_host u_host (.*);
   initial forever #20 ref_clk = ~ref_clk;
   // Pulses are counted mid-cycle, where they stand.
   always @(negedge ref_clk) begin
      hit_n += int'(sync_or_addr_hit === 1'b1);
      done_n += int'(rx_payload_done === 1'b1);
      sent_n += int'(tx_packet_done === 1'b1);
   end
   function automatic logic [7:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs[7:0];
   endfunction : rnd
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t byte %h not %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_flag(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t flag %b not %b", $time, got, exp);
      end
   endtask : chk_flag
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // Reference coder: checksum on plain bits, then line coding.
   task automatic put_byte(input logic [7:0] v, input bit cod, upd);
      bit c;
      for (int i = 7; i >= 0; i--) begin
         if (upd) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ v[i]) ? CRC_POLY : 16'h0000);
         c = v[i];
         if (cod && line_balance_sel == LB_WHITE) begin
            c = c ^ wh[0];
            wh = {wh[0] ^ wh[5], wh[8:1]};
         end
         chips.push_back(c);
         if (cod && line_balance_sel == LB_MANCH) chips.push_back(!c);
      end
   endtask : put_byte
   task automatic build(input bit bad_crc, bad_sync, crc_on);
      logic [15:0] fin;
      chips = {};
      crc = CRC_SEED;
      wh = WHITE_SEED;
      for (int i = 0; i < SB; i++) put_byte(SYNC[63-8*i -: 8] ^ 8'(bad_sync && i == 1), 0, 0);
      foreach (pay[i]) put_byte(pay[i], 1, 1);
      fin = ~crc ^ 16'(bad_crc);
      if (crc_on) put_byte(fin[15:8], 1, 0);
      if (crc_on) put_byte(fin[7:0], 1, 0);
   endtask : build
   task automatic tx_case(input logic [1:0] lb, input int n);
      bit got[$];
      pay = {};
      for (int i = 0; i < n; i++) pay.push_back(rnd());
      line_balance_sel = lb;
      max_len_setting = 8'(n);
      build(0, 0, 1);
      sent_n = 0;
      tx_go = 1'b1;
      fork
         u_host.send(pay, 2);
         for (int t = 0; t < 9000 && got.size() < chips.size(); t++) begin
            @(negedge ref_clk);
            if (tx_chip_en === 1'b1) got.push_back(tx_chip);
         end
      join
      for (int t = 0; t < 40 && sent_n == 0; t++) @(negedge ref_clk);
      chk_flag(got.size() == chips.size(), 1'b1);
      foreach (chips[i]) chk_flag(got[i], chips[i]);
      chk_byte(8'(sent_n), 8'h01);
      tx_go = 1'b0;
   endtask : tx_case
   // f: 0 bad sum, 1 keep bad, 2 bad sync, 3 sum off.
   task automatic rx_case(input logic [1:0] lb, af, input logic [7:0] ad,
                          input bit vl, input int n, mx, input logic [3:0] f = 4'h0);
      logic [7:0] got[$];
      bit acc, dn;
      pay = {};
      if (vl) pay.push_back(8'(n));
      if (af != AF_OFF) pay.push_back(ad);
      while (pay.size() < n + int'(vl)) pay.push_back(rnd());
      acc = !f[2] && (af == AF_OFF || ad == own_node_id || (af == AF_NODE_GROUP
            && ad == group_node_id)) && (!vl || n < mx);
      dn = acc && (f[3] || !f[0] || f[1]);
      line_balance_sel = lb;
      addr_filter_sel = af;
      var_len = vl;
      max_len_setting = 8'(mx);
      keep_bad_packet = f[1];
      checksum_enable = !f[3];
      build(f[0], f[2], !f[3]);
      hit_n = 0;
      done_n = 0;
      foreach (chips[i]) begin
         rx_chip = chips[i];
         rx_chip_en = 1'b1;
         repeat (2) @(negedge ref_clk);
         rx_chip_en = 1'b0;
         repeat (2) @(negedge ref_clk);
      end
      rx_chip = ~rx_chip;
      for (int t = 0; t < 60 && done_n == 0; t++) @(negedge ref_clk);
      u_host.take(got);
      chk_byte(8'(done_n), 8'(dn));
      if (acc || f[2]) chk_byte(8'(hit_n), 8'(acc));
      if (acc && !f[3]) chk_flag(checksum_pass, !f[0]);
      if (!dn) pay = {};
      chk_byte(8'(got.size()), 8'(pay.size()));
      foreach (pay[i]) chk_byte(got[i], pay[i]);
   endtask : rx_case
   initial begin
      repeat (90000) @(posedge ref_clk);
      errors++;
      give_verdict();
   end
   initial begin
      own_node_id = rnd();
      group_node_id = ~own_node_id;
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      tx_case(LB_NONE, 70);
      tx_case(LB_MANCH, 3);
      tx_case(LB_WHITE, 3);
      rx_mode = 1'b1;
      rx_case(LB_NONE, AF_OFF, 8'h00, 0, 4, 4);
      rx_case(LB_MANCH, AF_OFF, 8'h00, 0, 4, 4);
      rx_case(LB_WHITE, AF_OFF, 8'h00, 0, 4, 4);
      rx_case(LB_NONE, AF_NODE, own_node_id, 0, 3, 3);
      rx_case(LB_NONE, AF_NODE, group_node_id, 0, 3, 3);
      rx_case(LB_NONE, AF_NODE_GROUP, group_node_id, 0, 3, 3);
      rx_case(LB_NONE, AF_NODE_GROUP, own_node_id ^ 8'h01, 0, 3, 3);
      rx_case(LB_NONE, AF_OFF, 8'h00, 1, 5, 6);
      rx_case(LB_NONE, AF_OFF, 8'h00, 1, 6, 6);
      rx_case(LB_WHITE, AF_NODE, own_node_id, 1, 5, 255);
      rx_case(LB_NONE, AF_OFF, 8'h00, 0, 4, 4, 4'h1);
      rx_case(LB_NONE, AF_OFF, 8'h00, 0, 4, 4, 4'h3);
      rx_case(LB_NONE, AF_OFF, 8'h00, 0, 4, 4, 4'h4);
      rx_case(LB_NONE, AF_OFF, 8'h00, 0, 4, 4, 4'h8);
      give_verdict();
   end
endmodule : pfdc_top_tb
